// File: common/wdg_pkg.sv
/*
 * Shared constants of the safety watchdog unit: register offsets,
 * field positions, reset values, service key and tick timing.
 * Assumes a 25 MHz device clock and an APB bus with 32-bit data.
 */
package wdg_pkg;

   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          CNT_W         = 16;

   // register byte offsets
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_UPPER     = 8'h04;
   localparam logic [7:0]  OFF_LOWER     = 8'h08;
   localparam logic [7:0]  OFF_KEY       = 8'h0C;
   localparam logic [7:0]  OFF_STATUS    = 8'h10;
   localparam logic [7:0]  OFF_COUNT     = 8'h14;
   localparam logic [7:0]  OFF_NMI_PRD   = 8'h18;
   localparam logic [7:0]  OFF_LOCK      = 8'h1C;
   localparam logic [7:0]  OFF_NMI_ACK   = 8'h20;

   // control fields
   localparam int          CTRL_W        = 3;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_WIN_BIT  = 1;
   localparam int          CTRL_INT_BIT  = 2;
   localparam logic [2:0]  CTRL_RST      = 3'h1;

   // lock fields
   localparam int          LOCK_W        = 3;
   localparam int          LOCK_CTRL_BIT = 0;
   localparam int          LOCK_BND_BIT  = 1;
   localparam int          LOCK_NMI_BIT  = 2;

   // status and NMI acknowledge fields
   localparam int          ST_INT_BIT    = 0;
   localparam int          ST_NMI_BIT    = 1;
   localparam int          ST_PERM_BIT   = 2;
   localparam int          NMI_ACK_BIT   = 0;

   localparam logic [15:0] UPPER_RST     = 16'h1000;
   localparam logic [15:0] LOWER_RST     = 16'h0000;
   localparam logic [15:0] NMI_PRD_RST   = 16'h0800;

   // service key value is arbitrary
   localparam logic [31:0] SERVICE_KEY   = 32'h0000_5A5A;

   // counter tick period
   localparam int          CLK_NS        = 40;
   localparam int          TICK_NS       = 320;
   localparam logic [3:0]  TICK_DIV      = 4'((TICK_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [1:0] {
      NMI_IDLE = 2'b01,
      NMI_RUN  = 2'b10
   } nmi_state_t;

endpackage

// File: logic/wdg_counter.sv
/*
 * Tick-driven up counter used by the watchdog and the recovery timer.
 * Assumes i_tick is a one-cycle enable pulse in the i_mclk domain.
 */
`timescale 1ns/1ns
module wdg_counter
   import wdg_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_clr,
   input  wire logic             i_tick,
   output logic      [CNT_W-1:0] o_count
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;

   // saturate instead of wrapping so a missed compare cannot re-arm
   assign count_next = i_clr ? '0 :
                       (i_tick && count_reg != '1) ? count_reg + 1'b1 :
                       count_reg;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign o_count = count_reg;

endmodule // wdg_counter

// File: logic/wdg_prot_reg.sv
/*
 * One write-protected, lockable control register.
 * Assumes i_wr is an already decoded one-cycle write strobe.
 */
`timescale 1ns/1ns
module wdg_prot_reg
   import wdg_pkg::*;
#(
   parameter int           W   = 16,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst_n,
   input  wire logic         i_wr,
   input  wire logic         i_permit,
   input  wire logic         i_lock,
   input  wire logic [W-1:0] i_wdata,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] q_reg;
   logic         take;

   assign take = i_wr & i_permit & ~i_lock;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         q_reg <= RST;
      end else if (take) begin
         q_reg <= i_wdata;
      end
   end

   assign o_q = q_reg;

   // refused writes must leave every protected register alone
   no_permit_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_wr && !i_permit |=> $stable(o_q))
      else $error("protected write without permit");

   locked_reg_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_lock |=> $stable(o_q))
      else $error("locked register changed");

endmodule // wdg_prot_reg

// File: logic/safety_watchdog_unit.sv
/*
 * Safety watchdog unit: normal and windowed watchdog with key
 * servicing, reset or interrupt response, NMI recovery timer, and
 * protected, lockable control registers behind an APB slave.
 * Assumes APB and all strobes are synchronous to i_mclk (25 MHz).
 */
`timescale 1ns/1ns
module safety_watchdog_unit
   import wdg_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [DATA_W-1:0] i_pwdata,
   output logic      [DATA_W-1:0] o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   input  wire logic              i_permit_set,
   input  wire logic              i_permit_clr,
   input  wire logic              i_nmi,
   output logic                   o_warm_reset,
   output logic                   o_wdg_int,
   output logic                   o_nmi,
   output logic                   o_error_status,
   output logic                   o_nmi_reset
);

   // bus decode
   logic              setup;
   logic              wr;
   logic              sel_ctrl;
   logic              sel_upper;
   logic              sel_lower;
   logic              sel_key;
   logic              sel_status;
   logic              sel_count;
   logic              sel_nmi_prd;
   logic              sel_lock;
   logic              sel_nmi_ack;
   logic              mapped;
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] prdata_reg;

   assign setup       = i_psel & ~i_penable;
   assign wr          = i_psel & i_penable & i_pwrite;
   assign sel_ctrl    = (i_paddr == OFF_CTRL);
   assign sel_upper   = (i_paddr == OFF_UPPER);
   assign sel_lower   = (i_paddr == OFF_LOWER);
   assign sel_key     = (i_paddr == OFF_KEY);
   assign sel_status  = (i_paddr == OFF_STATUS);
   assign sel_count   = (i_paddr == OFF_COUNT);
   assign sel_nmi_prd = (i_paddr == OFF_NMI_PRD);
   assign sel_lock    = (i_paddr == OFF_LOCK);
   assign sel_nmi_ack = (i_paddr == OFF_NMI_ACK);
   assign mapped      = sel_ctrl | sel_upper | sel_lower | sel_key |
                        sel_status | sel_count | sel_nmi_prd |
                        sel_lock | sel_nmi_ack;

   // zero-wait slave; unmapped addresses answer with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;

   // permit and lock state
   logic              permit_reg;
   logic              permit_next;
   logic [LOCK_W-1:0] lock_reg;
   logic [LOCK_W-1:0] lock_next;
   logic              wr_lock_ok;

   assign permit_next = i_permit_set ? 1'b1 :
                        i_permit_clr ? 1'b0 : permit_reg;

   assign wr_lock_ok = wr & sel_lock & permit_reg;
   assign lock_next  = lock_reg |
                       (wr_lock_ok ? i_pwdata[LOCK_W-1:0] : '0);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         permit_reg <= 1'b0;
         lock_reg   <= '0;
      end else begin
         permit_reg <= permit_next;
         lock_reg   <= lock_next;
      end
   end

   // protected control registers
   logic [CTRL_W-1:0] ctrl;
   logic [CNT_W-1:0]  upper;
   logic [CNT_W-1:0]  lower;
   logic [CNT_W-1:0]  nmi_prd;

   // enabled, normal, reset response at reset
   wdg_prot_reg #(.W(CTRL_W), .RST(CTRL_RST)) u_ctrl (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_wr     (wr & sel_ctrl),
      .i_permit (permit_reg),
      .i_lock   (lock_reg[LOCK_CTRL_BIT]),
      .i_wdata  (i_pwdata[CTRL_W-1:0]),
      .o_q      (ctrl)
   );
   wdg_prot_reg #(.W(CNT_W), .RST(UPPER_RST)) u_upper (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_wr     (wr & sel_upper),
      .i_permit (permit_reg),
      .i_lock   (lock_reg[LOCK_BND_BIT]),
      .i_wdata  (i_pwdata[CNT_W-1:0]),
      .o_q      (upper)
   );
   wdg_prot_reg #(.W(CNT_W), .RST(LOWER_RST)) u_lower (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_wr     (wr & sel_lower),
      .i_permit (permit_reg),
      .i_lock   (lock_reg[LOCK_BND_BIT]),
      .i_wdata  (i_pwdata[CNT_W-1:0]),
      .o_q      (lower)
   );

   wdg_prot_reg #(.W(CNT_W), .RST(NMI_PRD_RST)) u_nmi_prd (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_wr     (wr & sel_nmi_prd),
      .i_permit (permit_reg),
      .i_lock   (lock_reg[LOCK_NMI_BIT]),
      .i_wdata  (i_pwdata[CNT_W-1:0]),
      .o_q      (nmi_prd)
   );

   // tick divider shared by both counters
   logic [3:0] div_reg;
   logic       tick;

   assign tick = (div_reg == TICK_DIV - 4'h1);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      end
   end

   // watchdog core
   logic             en;
   logic             win_mode;
   logic             int_mode;
   logic [CNT_W-1:0] count;
   logic             key_wr;
   logic             key_ok;
   logic             early;
   logic             good_key;
   logic             bad_key;
   logic             expire;
   logic             fail_evt;
   logic             restart;

   // a single bit, so modes exclude each other
   assign en       = ctrl[CTRL_EN_BIT];
   assign win_mode = ctrl[CTRL_WIN_BIT];
   assign int_mode = ctrl[CTRL_INT_BIT];

   // key writes are not protected; the key itself is the guard
   assign key_wr = wr & sel_key & en;
   assign key_ok = (i_pwdata == SERVICE_KEY);
   assign early  = win_mode & (count < lower);
   assign bad_key  = key_wr & (~key_ok | early);
   assign good_key = key_wr & key_ok & ~early;
   assign expire   = en & (count >= upper);
   assign fail_evt = bad_key | (expire & ~good_key);
   assign restart  = good_key | fail_evt | ~en;

   wdg_counter u_wd_cnt (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_clr   (restart),
      .i_tick  (tick & en),
      .o_count (count)
   );

   logic int_reg;
   logic int_next;
   logic rst_reg;
   logic int_clr;

   assign int_clr = (wr & sel_status & i_pwdata[ST_INT_BIT]) | good_key;

   // response chosen by mode bit; set wins
   assign int_next = (fail_evt & int_mode) ? 1'b1 :
                     int_clr ? 1'b0 : int_reg;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         int_reg <= 1'b0;
         rst_reg <= 1'b0;
      end else begin
         int_reg <= int_next;
         rst_reg <= fail_evt & ~int_mode;
      end
   end

   assign o_wdg_int    = int_reg;
   assign o_warm_reset = rst_reg;

   // NMI recovery timer
   nmi_state_t       nmi_state_reg;
   nmi_state_t       nmi_state_next;
   logic [CNT_W-1:0] nmi_count;
   logic             nmi_run;
   logic             nmi_ack;
   logic             nmi_hit;
   logic             nmi_rst_reg;

   assign nmi_run = (nmi_state_reg == NMI_RUN);
   assign nmi_ack = wr & sel_nmi_ack & i_pwdata[NMI_ACK_BIT];
   assign nmi_hit = nmi_run & ~nmi_ack & (nmi_count >= nmi_prd);

   // start on NMI, reset on expiry
   always_comb begin
      nmi_state_next = nmi_state_reg;
      case (nmi_state_reg)
         NMI_IDLE: begin
            if (i_nmi) begin
               nmi_state_next = NMI_RUN;
            end
         end
         NMI_RUN: begin
            if (nmi_ack || nmi_hit) begin
               nmi_state_next = NMI_IDLE;
            end
         end
         default: nmi_state_next = NMI_IDLE;
      endcase
   end

   wdg_counter u_nmi_cnt (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_clr   (~nmi_run),
      .i_tick  (tick),
      .o_count (nmi_count)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         nmi_state_reg <= NMI_IDLE;
         nmi_rst_reg   <= 1'b0;
      end else begin
         nmi_state_reg <= nmi_state_next;
         nmi_rst_reg   <= nmi_hit;
      end
   end

   assign o_nmi          = nmi_run;
   assign o_error_status = nmi_run;
   assign o_nmi_reset    = nmi_rst_reg;

   always_comb begin
      rd_mux = '0;
      if (sel_ctrl) begin
         rd_mux[CTRL_W-1:0] = ctrl;
      end else if (sel_upper) begin
         rd_mux[CNT_W-1:0] = upper;
      end else if (sel_lower) begin
         rd_mux[CNT_W-1:0] = lower;
      end else if (sel_status) begin
         rd_mux[ST_INT_BIT]  = int_reg;
         rd_mux[ST_NMI_BIT]  = nmi_run;
         rd_mux[ST_PERM_BIT] = permit_reg;
      end else if (sel_count) begin
         rd_mux[CNT_W-1:0] = count;
      end else if (sel_nmi_prd) begin
         rd_mux[CNT_W-1:0] = nmi_prd;
      end else if (sel_lock) begin
         rd_mux[LOCK_W-1:0] = lock_reg;
      end
   end

   // captured in setup so data stands through the access phase
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         prdata_reg <= '0;
      end else if (setup) begin
         prdata_reg <= rd_mux;
      end
   end

   assign o_prdata = prdata_reg;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   lock_sticky_a: assert property (
      lock_reg[LOCK_BND_BIT] |=> lock_reg[LOCK_BND_BIT] [*4])
      else $error("lock bit cleared");
   ctrl_read_a: assert property (
      setup && !i_pwrite && sel_ctrl
      |=> o_prdata[CTRL_W-1:0] == $past(ctrl))
      else $error("ctrl read mismatch");
   reset_resp_a: assert property (
      fail_evt && !int_mode |=> o_warm_reset ##1 !o_warm_reset)
      else $error("warm reset pulse missing");
   int_resp_a: assert property (
      fail_evt && int_mode |=> o_wdg_int && !o_warm_reset)
      else $error("interrupt response missing");
   key_restart_a: assert property (
      good_key |=> count == '0 && !o_warm_reset && !o_wdg_int)
      else $error("good key did not restart");
   early_key_a: assert property (
      key_wr && key_ok && win_mode && count < lower
      |=> (o_warm_reset || o_wdg_int) && count == '0)
      else $error("early key not failed");
   expiry_a: assert property (
      en && !key_wr && count >= upper |=> o_warm_reset || o_wdg_int)
      else $error("expiry not detected");
   nmi_pin_a: assert property (
      $rose(o_nmi) |-> $rose(o_error_status) && $past(i_nmi))
      else $error("error pin not with nmi");
   nmi_expiry_a: assert property (
      nmi_hit |=> o_nmi_reset && !o_nmi)
      else $error("recovery reset missing");

   cov_fail_c:   cover property (fail_evt && !int_mode);
   cov_win_c:    cover property (good_key && win_mode);
   cov_nmi_c:    cover property (nmi_run ##1 nmi_hit);
   cov_lock_c:   cover property (wr_lock_ok ##[1:20] (wr && sel_ctrl));

endmodule // safety_watchdog_unit

// File: tb/tb_top.sv
/* Self-checking bench for the safety watchdog unit: register access,
   timeout and key faults in both modes, recovery timer and locks.
   Assumes the package constants and a zero-wait APB slave. */
`timescale 1ns/1ns
module tb_top;
   import wdg_pkg::*;
   logic              i_mclk, i_rst_n, i_psel, i_penable, i_pwrite;
   logic [ADDR_W-1:0] i_paddr;
   logic [DATA_W-1:0] i_pwdata, o_prdata, rd;
   logic              o_pready, o_pslverr, i_permit_set, i_permit_clr;
   logic              i_nmi, o_warm_reset, o_wdg_int, o_nmi;
   logic              o_error_status, o_nmi_reset, err, got;
   int                n_errors, n_tests, n_cyc, n_wr, n0, u;

   safety_watchdog_unit dut (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_permit_set(i_permit_set),
      .i_permit_clr(i_permit_clr), .i_nmi(i_nmi),
      .o_warm_reset(o_warm_reset), .o_wdg_int(o_wdg_int), .o_nmi(o_nmi),
      .o_error_status(o_error_status), .o_nmi_reset(o_nmi_reset));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      n_cyc <= n_cyc + 1;
      if (o_warm_reset === 1'b1) n_wr <= n_wr + 1;
      if (n_cyc == 6000) begin
         n_errors++;
         wrap_up;
      end
   end

   function automatic int fail_cycles(input int ticks);
      return ticks * int'(TICK_DIV);
   endfunction

   function automatic logic [31:0] bad_key(input logic [31:0] r);
      return (r == SERVICE_KEY) ? ~r : r;
   endfunction

   task automatic wrap_up;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_pin(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask

   task automatic permit(input logic s);
      @(posedge i_mclk);
      i_permit_set <= s;
      i_permit_clr <= ~s;
      @(posedge i_mclk);
      i_permit_set <= 1'b0;
      i_permit_clr <= 1'b0;
   endtask

   task automatic nmi_pulse;
      @(posedge i_mclk);
      i_nmi <= 1'b1;
      @(posedge i_mclk);
      i_nmi <= 1'b0;
      #1;
   endtask

   // looks before each edge, so a pulse landing on the last edge is missed
   task automatic wait_hi(input int sel, input int lim);
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         #1;
         got = (sel == 0) ? o_warm_reset : (sel == 1) ? o_wdg_int
                                                      : o_nmi_reset;
         @(posedge i_mclk);
      end
   endtask

   task automatic count_small;
      apb(1'b0, OFF_COUNT, 32'h0);
      chk_pin(rd < 32'h2, 1'b1);
   endtask

   initial begin
      {i_rst_n, i_psel, i_penable, i_pwrite, i_nmi} = 5'h00;
      {i_permit_set, i_permit_clr} = 2'h0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      {n_errors, n_tests, n_cyc, n_wr} = {4{32'h0}};
      rd = $urandom(64911);
      repeat (8) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rdchk(OFF_CTRL, 32'(CTRL_RST));
      rdchk(OFF_UPPER, 32'(UPPER_RST));
      rdchk(OFF_LOWER, 32'(LOWER_RST));
      rdchk(OFF_NMI_PRD, 32'(NMI_PRD_RST));
      rdchk(OFF_LOCK, 32'h0);
      rdchk(OFF_STATUS, 32'h0);
      rdchk(OFF_NMI_ACK, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk_pin(err, 1'b1);
      chk_pin(o_pready, 1'b1);
      chk_reg(rd, 32'h0);
      u = 12 + ($urandom % 16);
      wr(OFF_UPPER, 32'h20);
      rdchk(OFF_UPPER, 32'(UPPER_RST));
      permit(1'b1);
      rdchk(OFF_STATUS, 32'h4);
      wr(OFF_UPPER, 32'(u));
      // permit dropped after the protected write
      permit(1'b0);
      rdchk(OFF_UPPER, 32'(u));
      wr(OFF_KEY, SERVICE_KEY);
      count_small;
      wait_hi(0, fail_cycles(u - 1) - 12);
      chk_pin(got, 1'b0);
      wait_hi(0, 24);
      chk_pin(got, 1'b1);
      for (int k = 0; k < 3; k++) begin
         wr(OFF_KEY, bad_key($urandom));
         wait_hi(0, 4);
         chk_pin(got, 1'b1);
      end
      permit(1'b1);
      wr(OFF_CTRL, 32'h5);
      n0 = n_wr;
      wait_hi(1, fail_cycles(u + 2));
      chk_pin(got, 1'b1);
      chk_reg(32'(n_wr), 32'(n0));
      repeat (20) @(posedge i_mclk);
      rdchk(OFF_STATUS, 32'h5);
      wr(OFF_STATUS, 32'h1);
      @(posedge i_mclk);
      #1;
      chk_pin(o_wdg_int, 1'b0);
      wr(OFF_UPPER, 32'd40);
      wr(OFF_LOWER, 32'd20);
      wr(OFF_CTRL, 32'h7);
      wait_hi(1, fail_cycles(42));
      chk_pin(got, 1'b1);
      wr(OFF_STATUS, 32'h1);
      wr(OFF_KEY, SERVICE_KEY);
      wait_hi(1, 4);
      chk_pin(got, 1'b1);
      wr(OFF_STATUS, 32'h1);
      repeat (fail_cycles(22)) @(posedge i_mclk);
      wr(OFF_KEY, SERVICE_KEY);
      count_small;
      chk_pin(o_wdg_int, 1'b0);
      repeat (fail_cycles(22)) @(posedge i_mclk);
      wr(OFF_KEY, bad_key($urandom));
      wait_hi(1, 4);
      chk_pin(got, 1'b1);
      wr(OFF_STATUS, 32'h1);
      wait_hi(1, fail_cycles(39) - 16);
      chk_pin(got, 1'b0);
      wait_hi(1, 30);
      chk_pin(got, 1'b1);
      wr(OFF_CTRL, 32'h3);
      wr(OFF_KEY, bad_key($urandom));
      wait_hi(0, 4);
      chk_pin(got, 1'b1);
      wr(OFF_NMI_PRD, 32'h6);
      nmi_pulse;
      chk_pin(o_nmi, 1'b1);
      chk_pin(o_error_status, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk_pin(rd[ST_NMI_BIT], 1'b1);
      wait_hi(2, fail_cycles(5) - 12);
      chk_pin(got, 1'b0);
      wait_hi(2, 30);
      chk_pin(got, 1'b1);
      chk_pin(o_nmi, 1'b0);
      nmi_pulse;
      wr(OFF_NMI_ACK, 32'h1);
      @(posedge i_mclk);
      #1;
      chk_pin(o_error_status, 1'b0);
      wait_hi(2, fail_cycles(8));
      chk_pin(got, 1'b0);
      wr(OFF_CTRL, 32'h2);
      wr(OFF_KEY, bad_key($urandom));
      wait_hi(0, fail_cycles(42));
      chk_pin(got, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wr(OFF_LOCK, 32'h7);
      wr(OFF_CTRL, 32'h0);
      rdchk(OFF_CTRL, 32'h3);
      wr(OFF_UPPER, 32'h55);
      rdchk(OFF_UPPER, 32'd40);
      wr(OFF_LOCK, 32'h0);
      rdchk(OFF_LOCK, 32'h7);
      permit(1'b0);
      rdchk(OFF_NMI_PRD, 32'h6);
      wrap_up;
   end
endmodule // tb_top
